/* File: rtl/mbe_master_engine.sv */
`timescale 1ns/10ps
`include "mbe_defines.svh"
module mbe_master_engine #(
	parameter int RX_DEPTH = 2
) (
	input wire logic clk, // system clock 40 MHz
	input wire logic rst, // async reset, high
	input wire mbe_pkg::mbe_req_t req, // request pulses and write data
	input wire mbe_pkg::mbe_clr_t clr, // flag clear pulses
	input wire logic [`MBE_BAUD_W-1:0] baudValue, // baud reload value
	input wire logic sclIn, // clock line level
	output logic sclOut, // clock line drive value
	output logic sclOe, // clock line pulled low
	input wire logic sdaIn, // data line level
	output logic sdaOut, // data line drive value
	output logic sdaOe, // data line pulled low
	output logic rxValid, // received byte available
	output logic [7:0] rxData, // received byte
	input wire logic rxReady, // processor reads byte
	output mbe_pkg::mbe_flag_t flags // status and busy bits
);
	import mbe_pkg::*;
	mbe_core_t s, next_s;
	logic idle, timeout, startEv, pushValid, pushReady;

	mbe_pair_buffer #(.WIDTH(8), .DEPTH(RX_DEPTH)) rxBuf (
		.clk(clk),
		.rst(rst),
		.inValid(pushValid),
		.inData(s.sh),
		.inReady(pushReady),
		.outValid(rxValid),
		.outData(rxData),
		.outReady(rxReady)
	);

	assign idle = (s.st == ST_IDLE);
	assign timeout = (s.bc == `MBE_BAUD_ZERO);
	assign startEv = s.sclF && s.sdaF && (s.sdaSy[2] == s.sdaSy[1]) && !s.sdaSy[1];
	assign pushValid = (s.st == ST_RX_PUSH);
	// R27 open drain
	assign sclOut = `MBE_LINE_LOW;
	assign sdaOut = `MBE_LINE_LOW;
	assign sclOe = s.sclLow;
	assign sdaOe = s.sdaLow;

	always_comb begin
		flags.restartRequest = s.st inside {ST_RS_PULL, ST_RS_RELSDA, ST_RS_RELSCL,
			ST_RS_HIGH, ST_RS_SDALOW};
		flags.receiveRequest = s.st inside {ST_RX_LOW, ST_RX_REL, ST_RX_HIGH, ST_RX_PUSH};
		flags.ackSequenceRequest = s.st inside {ST_AK_LOW, ST_AK_REL, ST_AK_HIGH};
		flags.slaveAckStatus = s.slave_ack_status;
		// R18 full clears once reads empty the buffer and no send is pending
		flags.bufferFull = s.txFull || rxValid;
		flags.writeCollision = s.write_collision_flag;
		flags.receiveOverflow = s.ovf;
		flags.portInterrupt = s.intr;
		flags.startDetected = s.startSeen;
		flags.busCollision = s.bcol;
	end

	always_comb begin
		logic setIf, setWcol, setOvf, setBcol, taken;
		setIf = 1'b0;
		setWcol = 1'b0;
		setOvf = 1'b0;
		setBcol = 1'b0;
		taken = 1'b0;
		next_s = s;
		next_s.sclSy = {s.sclSy[1:0], sclIn};
		next_s.sdaSy = {s.sdaSy[1:0], sdaIn};
		if (s.sclSy[2] == s.sclSy[1]) begin
			next_s.sclF = s.sclSy[2];
		end
		if (s.sdaSy[2] == s.sdaSy[1]) begin
			next_s.sdaF = s.sdaSy[2];
		end
		// R24 countdown to rollover
		if (!timeout) begin
			next_s.bc = s.bc - `MBE_BAUD_ONE;
		end
		case (s.st)
			ST_IDLE: begin
				// R1 R15 requests only in idle
				if (req.restart) begin
					taken = 1'b1;
					next_s.sclLow = 1'b1;
					next_s.st = ST_RS_PULL;
				end else if (req.ackSeq) begin
					// R26 drive chosen ack value
					taken = 1'b1;
					next_s.sclLow = 1'b1;
					next_s.sdaLow = !req.ackValue;
					next_s.bc = baudValue;
					next_s.st = ST_AK_LOW;
				end else if (req.receive) begin
					taken = 1'b1;
					next_s.sclLow = 1'b1;
					next_s.sdaLow = 1'b0;
					next_s.bitCnt = `MBE_CNT_ZERO;
					next_s.bc = baudValue;
					next_s.st = ST_RX_LOW;
				end
				// R7 R9 write starts sending msb first
				if (req.write && !taken) begin
					next_s.sh = req.data;
					next_s.txFull = 1'b1;
					next_s.sclLow = 1'b1;
					next_s.sdaLow = !req.data[`MBE_MSB];
					next_s.bitCnt = `MBE_CNT_ZERO;
					next_s.bc = baudValue;
					next_s.st = ST_TX_LOW;
				end
			end
			// R2 wait clock low, then release data
			ST_RS_PULL: begin
				if (!s.sclF) begin
					next_s.sdaLow = 1'b0;
					next_s.bc = baudValue;
					next_s.st = ST_RS_RELSDA;
				end
			end
			// R3 release clock once data high
			ST_RS_RELSDA: begin
				if (timeout && s.sdaF) begin
					next_s.sclLow = 1'b0;
					next_s.st = ST_RS_RELSCL;
				end
			end
			ST_RS_RELSCL: begin
				if (s.sclF) begin
					// R6 data low at clock rise
					if (!s.sdaF) begin
						setBcol = 1'b1;
					end else begin
						next_s.bc = baudValue;
						next_s.st = ST_RS_HIGH;
					end
				end
			end
			ST_RS_HIGH: begin
				// R6 clock lost before data low
				if (!s.sclF) begin
					setBcol = 1'b1;
				end else if (timeout) begin
					next_s.sdaLow = 1'b1;
					next_s.bc = baudValue;
					next_s.st = ST_RS_SDALOW;
				end
			end
			ST_RS_SDALOW: begin
				// R4 R5 R23 finish after timeout, data held low
				if (timeout) begin
					next_s.sclLow = 1'b1;
					setIf = 1'b1;
					next_s.st = ST_IDLE;
				end
			end
			// R8 clock low one period
			ST_TX_LOW: begin
				if (timeout) begin
					next_s.sclLow = 1'b0;
					next_s.st = ST_TX_REL;
				end
			end
			// R25 counter waits for clock high
			ST_TX_REL: begin
				if (s.sclF) begin
					// R11 latch ninth-bit ack
					if (s.bitCnt == `MBE_CNT_NINTH) begin
						next_s.slave_ack_status = s.sdaF;
					end
					next_s.bc = baudValue;
					next_s.st = ST_TX_HIGH;
				end
			end
			ST_TX_HIGH: begin
				if (timeout) begin
					next_s.sclLow = 1'b1;
					next_s.bitCnt = s.bitCnt + `MBE_CNT_W'(1);
					next_s.bc = baudValue;
					next_s.st = ST_TX_LOW;
					if (s.bitCnt == `MBE_CNT_EIGHTH) begin
						// R10 eighth fall releases data
						next_s.txFull = 1'b0;
						next_s.sdaLow = 1'b0;
					end else if (s.bitCnt == `MBE_CNT_NINTH) begin
						// R12 suspend with clock low
						setIf = 1'b1;
						next_s.sdaLow = 1'b0;
						next_s.st = ST_IDLE;
					end else begin
						// R8 next bit after the fall
						next_s.sh = {s.sh[6:0], 1'b0};
						next_s.sdaLow = !s.sh[`MBE_MSB-1];
					end
				end
			end
			// R16 receive clock toggles per rollover
			ST_RX_LOW: begin
				if (timeout) begin
					next_s.sclLow = 1'b0;
					next_s.st = ST_RX_REL;
				end
			end
			ST_RX_REL: begin
				if (s.sclF) begin
					next_s.sh = {s.sh[6:0], s.sdaF};
					next_s.bc = baudValue;
					next_s.st = ST_RX_HIGH;
				end
			end
			ST_RX_HIGH: begin
				if (timeout) begin
					next_s.sclLow = 1'b1;
					next_s.bitCnt = s.bitCnt + `MBE_CNT_W'(1);
					next_s.bc = baudValue;
					next_s.st = (s.bitCnt == `MBE_CNT_EIGHTH) ? ST_RX_PUSH : ST_RX_LOW;
				end
			end
			// R17 store byte, flag, return idle
			ST_RX_PUSH: begin
				if (pushReady) begin
					// R19 overflow when still full
					setOvf = rxValid;
					setIf = 1'b1;
					next_s.st = ST_IDLE;
				end
			end
			ST_AK_LOW: begin
				if (timeout) begin
					next_s.sclLow = 1'b0;
					next_s.st = ST_AK_REL;
				end
			end
			ST_AK_REL: begin
				if (s.sclF) begin
					next_s.bc = baudValue;
					next_s.st = ST_AK_HIGH;
				end
			end
			ST_AK_HIGH: begin
				if (timeout) begin
					next_s.sclLow = 1'b1;
					setIf = 1'b1;
					next_s.st = ST_IDLE;
				end
			end
			default: begin
				next_s.st = ST_IDLE;
			end
		endcase
		// R13 R20 write while busy is dropped
		if (req.write && (!idle || taken)) begin
			setWcol = 1'b1;
		end
		if (setBcol) begin
			next_s.sclLow = 1'b0;
			next_s.sdaLow = 1'b0;
			next_s.st = ST_IDLE;
		end
		next_s.write_collision_flag = (s.write_collision_flag && !clr.clrCollision) || setWcol;
		next_s.ovf = (s.ovf && !clr.clrOverflow) || setOvf;
		next_s.intr = (s.intr && !clr.clrInterrupt) || setIf;
		next_s.bcol = (s.bcol && !clr.clrBusCollision) || setBcol;
		// R5 start seen at once
		next_s.startSeen = (s.startSeen && !clr.clrStart) || startEv;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.sclSy <= `MBE_SYNC_IDLE;
			s.sdaSy <= `MBE_SYNC_IDLE;
			s.sclF <= 1'b1;
			s.sdaF <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	restart_ignored_a: assert property ((req.restart && !idle && !flags.restartRequest)
		|=> !flags.restartRequest) // R1
		else $error("restart taken while busy");
	restart_release_a: assert property ((s.st == ST_RS_PULL && !s.sclF)
		|=> !sdaOe && sclOe && s.bc == $past(baudValue)) // R2
		else $error("restart did not release data with reload");
	restart_end_a: assert property (($fell(flags.restartRequest) && !s.bcol)
		|-> sdaOe && sclOe && s.intr) // R4
		else $error("restart end left data released");
	write_starts_a: assert property ((req.write && idle && !req.restart && !req.ackSeq
		&& !req.receive) |=> flags.bufferFull && s.st == ST_TX_LOW) // R7
		else $error("buffer write did not start transmit");
	eighth_release_a: assert property ($fell(s.txFull) |-> !sdaOe && sclOe) // R10
		else $error("data held after eighth fall");
	ninth_hold_a: assert property ((s.st == ST_TX_HIGH && timeout
		&& s.bitCnt == `MBE_CNT_NINTH) |=> s.intr && sclOe && !sdaOe && idle) // R12
		else $error("ninth clock did not suspend");
	busy_write_a: assert property ((req.write && !idle) |=> s.write_collision_flag && // R13
		($stable(s.sh) || s.sh[7:1] == $past(s.sh[6:0])))
		else $error("write while busy not refused");
	release_wait_a: assert property ((s.st inside {ST_TX_REL, ST_RX_REL} && !s.sclF)
		|=> $stable(s.st) && !sclOe) // R25
		else $error("counter ran while clock held low");
	overflow_set_a: assert property ((pushValid && pushReady && rxValid)
		|=> s.ovf) // R19
		else $error("overflow not flagged");
	receive_ignored_a: assert property ((req.receive && s.txFull)
		|=> !flags.receiveRequest) // R15
		else $error("receive taken while sending");
	never_high_a: assert property ((sclOut == `MBE_LINE_LOW) && (sdaOut == `MBE_LINE_LOW)) // R27
		else $error("line driven high");

	restart_done_c: cover property ($fell(flags.restartRequest) && !s.bcol);
	tx_byte_c: cover property ($fell(s.txFull) ##[1:300] $rose(s.intr));
	rx_byte_c: cover property (pushValid && pushReady);
	collision_c: cover property ($rose(s.bcol));
endmodule // mbe_master_engine

/* File: rtl/mbe_defines.svh */
// Overview of operation
// R1: restart request ignored unless engine idle
// R2: restart pulls clock low, then releases data
// R3: clock released, both high, data low, clock low
// R4: restart self-clears, no reload, data stays low
// R5: start seen at once, interrupt after timeout
// R6: restart collision on low data or clock
// R7: buffer write sets full and starts sending
// R8: data changes after fall; low/high one period
// R9: address is seven bits plus read/write bit
// R10: eighth fall clears full, releases data
// R11: ninth-bit acknowledge latched into status
// R12: after ninth clock: interrupt, clock held low
// R13: write while sending discarded, collision flagged
// R14: software clears collision before next send
// R15: receive request ignored unless engine idle
// R16: receive toggles clock, shifts data in
// R17: eighth receive fall: store, flag, hold, idle
// R18: reading the buffer clears buffer full; stays set here while a second byte is held
// R19: overflow when byte arrives while full
// R20: write while receiving discarded, collision flagged
// R21: software sends start, address, then data bytes
// R22: software reads with read bit, then acknowledges
// R23: interrupt only after restart fully completes
// R24: each period is baud value reload to rollover
// R25: counter waits until released clock reads high
// R26: acknowledge sequence drives chosen value one pulse
// R27: lines only pulled low or released
`ifndef MBE_DEFINES_SVH
`define MBE_DEFINES_SVH
`define MBE_BAUD_W 8
`define MBE_CNT_W 4
`define MBE_CNT_ZERO 4'h0
`define MBE_CNT_EIGHTH 4'h7
`define MBE_CNT_NINTH 4'h8
`define MBE_BAUD_ZERO 8'h00
`define MBE_BAUD_ONE 8'h01
`define MBE_BYTE_ZERO 8'h00
`define MBE_SYNC_IDLE 3'h7
`define MBE_LINE_LOW 1'b0
`define MBE_MSB 7
`endif

/* File: rtl/mbe_pkg.sv */
`include "mbe_defines.svh"
package mbe_pkg;
	typedef enum logic [3:0] {
		ST_IDLE, ST_RS_PULL, ST_RS_RELSDA, ST_RS_RELSCL, ST_RS_HIGH, ST_RS_SDALOW,
		ST_TX_LOW, ST_TX_REL, ST_TX_HIGH, ST_RX_LOW, ST_RX_REL, ST_RX_HIGH, ST_RX_PUSH,
		ST_AK_LOW, ST_AK_REL, ST_AK_HIGH
	} mbe_state_t;
	typedef struct packed {
		logic restart;
		logic receive;
		logic ackSeq;
		logic ackValue;
		logic write;
		logic [7:0] data;
	} mbe_req_t;
	typedef struct packed {
		logic clrCollision;
		logic clrOverflow;
		logic clrInterrupt;
		logic clrStart;
		logic clrBusCollision;
	} mbe_clr_t;
	typedef struct packed {
		logic restartRequest;
		logic receiveRequest;
		logic ackSequenceRequest;
		logic slaveAckStatus;
		logic bufferFull;
		logic writeCollision;
		logic receiveOverflow;
		logic portInterrupt;
		logic startDetected;
		logic busCollision;
	} mbe_flag_t;
	typedef struct packed {
		mbe_state_t st;
		logic [`MBE_BAUD_W-1:0] bc;
		logic [`MBE_CNT_W-1:0] bitCnt;
		logic [7:0] sh;
		logic txFull;
		logic sclLow;
		logic sdaLow;
		logic [2:0] sclSy;
		logic [2:0] sdaSy;
		logic sclF;
		logic sdaF;
		logic slave_ack_status;
		logic write_collision_flag;
		logic ovf;
		logic intr;
		logic startSeen;
		logic bcol;
	} mbe_core_t;
endpackage

/* File: rtl/mbe_pair_buffer.sv */
`timescale 1ns/10ps
module mbe_pair_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input wire logic clk, // system clock
	input wire logic rst, // async reset, high
	input wire logic inValid, // word offered
	input wire logic [WIDTH-1:0] inData, // offered word
	output logic inReady, // room for a word
	output logic outValid, // word available
	output logic [WIDTH-1:0] outData, // oldest word
	input wire logic outReady // drain takes word
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] rdPtr;
		logic [PW-1:0] wrPtr;
		logic [CW-1:0] count;
	} mbe_buf_t;
	mbe_buf_t s, next_s;
	logic push, pop;

	assign inReady = (s.count != CW'(DEPTH));
	assign outValid = (s.count != '0);
	assign outData = s.mem[s.rdPtr];
	assign push = inValid && inReady;
	assign pop = outValid && outReady;

	always_comb begin
		next_s = s;
		if (push) begin
			next_s.mem[s.wrPtr] = inData;
			next_s.wrPtr = (s.wrPtr == PW'(DEPTH - 1)) ? '0 : PW'(s.wrPtr + PW'(1));
		end
		if (pop) begin
			next_s.rdPtr = (s.rdPtr == PW'(DEPTH - 1)) ? '0 : PW'(s.rdPtr + PW'(1));
		end
		if (push && !pop) begin
			next_s.count = CW'(s.count + CW'(1));
		end else if (pop && !push) begin
			next_s.count = CW'(s.count - CW'(1));
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	count_bound_a: assert property (@(posedge clk) disable iff (rst) s.count <= CW'(DEPTH))
		else $error("buffer count beyond depth");
	full_refuse_a: assert property (@(posedge clk) disable iff (rst)
		(!inReady && !pop) |=> $stable(s.count))
		else $error("full buffer took a word");
endmodule // mbe_pair_buffer

/* File: dv/mbe_slave_model.sv */
`timescale 1ns/10ps
module mbe_slave_model (
	input wire logic scl, // clock line level
	input wire logic frameRst, // restart bit count
	input wire logic sendMode, // slave sends its byte
	input wire logic [7:0] sendByte, // byte to send
	input wire logic ackOn, // acknowledge a byte
	input wire logic stretch, // hold clock low longer
	output logic sdaPull, // pulls data low
	output logic sclPull // pulls clock low
);
	logic [3:0] cnt;
	always @(negedge scl or posedge frameRst) begin
		if (frameRst) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
	always_comb begin
		if (sendMode) begin
			sdaPull = (cnt < 4'h8) && !sendByte[3'h7 - cnt[2:0]];
		end else begin
			sdaPull = ackOn && (cnt == 4'h8);
		end
	end
	initial sclPull = 1'b0;
	always @(negedge scl) begin
		if (stretch) begin
			sclPull = 1'b1;
			#300 sclPull = 1'b0;
		end
	end
endmodule // mbe_slave_model

/* File: dv/mbe_master_engine_tb.sv */
`timescale 1ns/10ps
module mbe_master_engine_tb;
	import mbe_pkg::*;
	logic clk, rst, sclOut, sclOe, sdaOut, sdaOe, rxValid, rxReady;
	logic sclPull, sdaPull, tbSclPull, ackOn, sendMode, stretch, frameRst;
	logic [7:0] rxData, slvByte, baud;
	logic [8:0] seen;
	mbe_req_t req;
	mbe_clr_t clr;
	mbe_flag_t flags;
	int errors, testsRun, n;
	// open-drain wiring with pull-ups
	wire logic sclLine = !(sclOe | sclPull | tbSclPull);
	wire logic sdaLine = !(sdaOe | sdaPull);

	mbe_master_engine uut (
		.clk(clk), .rst(rst), .req(req), .clr(clr), .baudValue(baud), .sclIn(sclLine),
		.sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
		.rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .flags(flags)
	);
	mbe_slave_model slave (
		.scl(sclLine), .frameRst(frameRst), .sendMode(sendMode), .sendByte(slvByte),
		.ackOn(ackOn), .stretch(stretch), .sdaPull(sdaPull), .sclPull(sclPull)
	);

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	always @(posedge sclLine) begin
		seen <= {seen[7:0], sdaLine};
	end

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		testsRun++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#2;
	endtask
	// k bits: restart, receive, ackSeq, write; d[0] is the ack value
	task automatic doReq(input logic [3:0] k, input logic [7:0] d);
		cyc(1);
		req = '{restart: k[3], receive: k[2], ackSeq: k[1], ackValue: d[0], write: k[0], data: d};
		cyc(1);
		req = '0;
	endtask
	task automatic doClr(input mbe_clr_t c);
		cyc(1);
		clr = c;
		cyc(1);
		clr = '0;
	endtask
	task automatic waitIrq(input string what);
		int w;
		w = 0;
		while (flags.portInterrupt !== 1'b1 && w < 4000) begin
			cyc(1);
			w++;
		end
		chk(what, 16'h0001, {15'h0000, flags.portInterrupt});
		doClr(5'h04);
	endtask
	task automatic frame(input logic snd, input logic [7:0] b, input logic ack, input logic st);
		sendMode = snd;
		slvByte = b;
		ackOn = ack;
		stretch = st;
		frameRst = 1'b1;
		#1 frameRst = 1'b0;
	endtask
	task automatic pop(input logic [7:0] exp);
		cyc(1);
		chk("rxData", {8'h00, exp}, {8'h00, rxData});
		rxReady = 1'b1;
		cyc(1);
		rxReady = 1'b0;
	endtask
	task automatic endTest(input string name);
		$display("test %s done, errors so far %0d", name, errors);
	endtask
	task automatic results;
		$display("comparisons %0d mismatches %0d", testsRun, errors);
		if (errors == 0 && testsRun > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	initial begin
		#400000;
		errors++;
		$display("BAD watchdog expected finish seen hang");
		results();
	end

	initial begin
		rst = 1'b1;
		req = '0;
		clr = '0;
		rxReady = 1'b0;
		tbSclPull = 1'b0;
		frameRst = 1'b0;
		baud = 8'h03;
		errors = 0;
		testsRun = 0;
		frame(1'b0, 8'h00, 1'b0, 1'b0);
		cyc(16);
		rst = 1'b0;
		chk("reset lines", 16'h0000, {14'h0000, sclOe, sdaOe});
		chk("reset flags", 16'h0000, {6'h00, flags});
		endTest("reset");
		cyc(4);
		doReq(4'h8, 8'h00);
		chk("restart busy", 16'h0003, {14'h0000, flags.restartRequest, sclOe});
		doReq(4'h4, 8'h00);
		doReq(4'h1, 8'h77);
		waitIrq("restart irq");
		chk("restart end", 16'h0027, {10'h000, flags.writeCollision, flags.busCollision,
			flags.receiveRequest, flags.startDetected, sclOe, sdaOe});
		chk("restart idle", 16'h0000, {15'h0000, flags.restartRequest});
		doClr(5'h12);
		endTest("restart");
		frame(1'b0, 8'h00, 1'b1, 1'b1);
		doReq(4'h1, 8'hA5);
		chk("full on write", 16'h0003, {14'h0000, flags.bufferFull, sclOe});
		doReq(4'h1, 8'hFF);
		doReq(4'h8, 8'h00);
		doReq(4'h4, 8'h00);
		chk("busy requests", 16'h0000, {14'h0000, flags.restartRequest, flags.receiveRequest});
		waitIrq("tx irq");
		chk("tx wire", 16'h014A, {7'h00, seen});
		chk("tx end", 16'h0012, {11'h000, flags.writeCollision, flags.slaveAckStatus,
			flags.bufferFull, sclOe, sdaOe});
		doClr(5'h10);
		endTest("tx ack stretched");
		for (int i = 0; i < 2; i++) begin
			baud = (i == 0) ? 8'h03 : 8'h06;
			frame(1'b0, 8'h00, 1'b0, 1'b0);
			doReq(4'h1, 8'h5A);
			n = 0;
			while (sclOe === 1'b1 && n < 50) begin
				cyc(1);
				n++;
			end
			chk("low period", {8'h00, baud} + 16'h0001, n[15:0]);
			waitIrq("nack irq");
			chk("nack wire", 16'h02B5, {6'h00, flags.slaveAckStatus, seen});
		end
		baud = 8'h03;
		endTest("tx nack");
		frame(1'b1, 8'h3C, 1'b0, 1'b0);
		doReq(4'h4, 8'h00);
		chk("rx busy", 16'h0001, {15'h0000, flags.receiveRequest});
		doReq(4'h1, 8'h11);
		waitIrq("rx irq");
		chk("rx end", 16'h0039, {10'h000, flags.writeCollision, rxValid, flags.bufferFull,
			flags.receiveRequest, flags.receiveOverflow, sclOe});
		doClr(5'h10);
		doReq(4'h2, 8'h00);
		waitIrq("ack irq");
		chk("ack wire", 16'h0003, {13'h0000, seen[0], sclOe, sdaOe});
		frame(1'b1, 8'hC3, 1'b0, 1'b0);
		doReq(4'h4, 8'h00);
		waitIrq("rx2 irq");
		chk("overflow", 16'h0001, {15'h0000, flags.receiveOverflow});
		pop(8'h3C);
		pop(8'hC3);
		cyc(1);
		chk("full cleared", 16'h0000, {15'h0000, flags.bufferFull});
		endTest("rx");
		baud = 8'h0F;
		doReq(4'h8, 8'h00);
		n = 0;
		while (!(sclOe === 1'b0 && sclLine === 1'b1) && n < 200) begin
			cyc(1);
			n++;
		end
		cyc(5);
		tbSclPull = 1'b1;
		cyc(4);
		tbSclPull = 1'b0;
		cyc(40);
		chk("restart collision", 16'h0001, {15'h0000, flags.busCollision});
		doClr(5'h09);
		chk("flags cleared", 16'h0000, {14'h0000, flags.receiveOverflow, flags.busCollision});
		endTest("collision");
		results();
	end
endmodule // mbe_master_engine_tb
